/* File: src/efe_top.sv */
// Added by the designer: the placing of the registers and the AHB-Lite register port.
`include "efe_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module efe_top (
  input  wire logic               CLK,
  input  wire logic               ARST_N,
  input  wire logic               HSEL,
  input  wire logic [31:0]        HADDR,
  input  wire logic [1:0]         HTRANS,
  input  wire logic               HWRITE,
  input  wire logic [2:0]         HSIZE,
  input  wire logic [31:0]        HWDATA,
  input  wire logic               HREADY,
  output logic [31:0]             HRDATA,
  output logic                    HREADYOUT,
  output logic                    HRESP,
  input  wire efe_pkg::efe_quad_t ENC_I,
  input  wire logic [2:0]         HALL_I,
  input  wire efe_pkg::efe_quad_t X5_I,
  output efe_pkg::efe_quad_t      X5_O,
  output efe_pkg::efe_quad_t      X5_OE,
  input  wire logic               SSIF_DAT_I,
  output logic                    SSIF_CLK_O,
  output logic                    WAKE_SHAKE_REQ,
  output logic [2:0]              COMM_HALL,
  output logic [11:0]             COMM_PHASE
);
  import efe_pkg::*;

  localparam logic [4:0] EDGE_CYC   = 5'(`EFE_EDGE_CYC);
  localparam logic [4:0] HALF_CYC   = 5'(`EFE_SSIR_HALF_CYC);
  localparam logic [9:0] TOUT_SHORT = 10'(`EFE_TOUT_SHORT_CYC);
  localparam logic [9:0] TOUT_LONG  = 10'(`EFE_TOUT_LONG_CYC);

  function automatic logic [31:0] gray2bin(input logic [31:0] g);
    logic [31:0] b;
    b = '0;
    b[31] = g[31];
    for (int i = 30; i >= 0; i--) begin
      b[i] = b[i + 1] ^ g[i];
    end
    return b;
  endfunction

  logic        rst_s1_r;
  logic        rst_n;
  logic [9:0]  pin_s1_r;
  logic [9:0]  pin_s2_r;
  efe_quad_t   enc_s;
  efe_quad_t   x5_s;
  logic [2:0]  hall_s;
  logic        ssif_dat_s;

  // Reset is released through two flops so every block leaves reset together
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_s1_r <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n    <= rst_s1_r;
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
    end else begin
      pin_s1_r <= {SSIF_DAT_I, HALL_I, X5_I, ENC_I};
      pin_s2_r <= pin_s1_r;
    end
  end

  assign enc_s      = efe_quad_t'(pin_s2_r[2:0]);
  assign x5_s       = efe_quad_t'(pin_s2_r[5:3]);
  assign hall_s     = pin_s2_r[8:6];
  assign ssif_dat_s = pin_s2_r[9];

  efe_ctrl_t   ctrl_r;
  efe_ctrl_t   ctrl_nxt;
  logic [23:0] idx_ofs_r;
  logic [23:0] idx_ofs_nxt;
  logic [23:0] ang_r;
  logic [23:0] ang_nxt;
  logic [15:0] turns_r;
  logic [15:0] turns_nxt;
  logic [11:0] phase_r;
  logic [11:0] phase_nxt;
  logic [31:0] fb_idx_r;
  logic [31:0] fb_idx_nxt;
  logic [31:0] ssi_rx_r;
  logic [31:0] ssi_rx_nxt;
  logic        wr_pend_r;
  logic        wr_pend_nxt;
  logic [7:0]  wr_addr_r;
  logic [7:0]  wr_addr_nxt;
  logic [31:0] hrdata_nxt;
  logic        addr_ok;
  logic [31:0] fb_cnt;
  logic [31:0] gear_cnt;
  logic        fb_idx_evt;
  logic        fb_en;
  logic        gear_en;
  logic        tx_busy;
  logic        tx_dat;
  logic        rx_busy;
  logic [31:0] status;
  logic [9:0]  tout_cyc;
  logic [4:0]  mt_w;
  logic [5:0]  nbits;

  assign addr_ok = HSEL & HTRANS[1] & HREADY;
  assign tout_cyc = ctrl_r.serial_frame_timeout ? TOUT_LONG : TOUT_SHORT;
  assign fb_en = (ctrl_r.feedback_type_select == `EFE_FB_QUAD_STORE) |
                 (ctrl_r.feedback_type_select == `EFE_FB_QUAD_SHAKE) |
                 (ctrl_r.feedback_type_select == `EFE_FB_HALL);
  // A slave in gearing listens only while its own emulation is off
  assign gear_en = (ctrl_r.emulation_output_mode == `EFE_EMU_OFF) &
                   ((ctrl_r.gearing_input_mode == `EFE_GEAR_QUAD) |
                    (ctrl_r.gearing_input_mode == `EFE_GEAR_STEP));

  always_comb begin
    mt_w = ctrl_r.multiturn_bit_width;
    if (mt_w < `EFE_MT_MIN) begin
      mt_w = `EFE_MT_MIN;
    end else if (mt_w > `EFE_MT_MAX) begin
      mt_w = `EFE_MT_MAX;
    end
    nbits = {1'b0, mt_w} + `EFE_ST_BITS;
  end

  // Host register block: zero wait states, read data captured at address
  always_comb begin
    wr_pend_nxt = addr_ok & HWRITE;
    wr_addr_nxt = addr_ok ? HADDR[7:0] : wr_addr_r;
    hrdata_nxt  = HRDATA;
    if (addr_ok & ~HWRITE) begin
      unique case (HADDR[7:0])
        `EFE_OFS_CTRL:        hrdata_nxt = ctrl_r;
        `EFE_OFS_IDX_OFS:     hrdata_nxt = {8'h00, idx_ofs_r};
        `EFE_OFS_SHAFT_ANG:   hrdata_nxt = {8'h00, ang_r};
        `EFE_OFS_SHAFT_TURNS: hrdata_nxt = {16'h0000, turns_r};
        `EFE_OFS_PHASE:       hrdata_nxt = {20'h00000, phase_r};
        `EFE_OFS_FB_CNT:      hrdata_nxt = fb_cnt;
        `EFE_OFS_GEAR_CNT:    hrdata_nxt = gear_cnt;
        `EFE_OFS_SSI_RX:      hrdata_nxt = ssi_rx_r;
        `EFE_OFS_STATUS:      hrdata_nxt = status;
        `EFE_OFS_FB_IDX:      hrdata_nxt = fb_idx_r;
        default:              hrdata_nxt = '0;
      endcase
    end
    ctrl_nxt    = ctrl_r;
    idx_ofs_nxt = idx_ofs_r;
    ang_nxt     = ang_r;
    turns_nxt   = turns_r;
    phase_nxt   = phase_r;
    if (wr_pend_r) begin
      unique case (wr_addr_r)
        `EFE_OFS_CTRL:        ctrl_nxt    = efe_ctrl_t'(HWDATA);
        `EFE_OFS_IDX_OFS:     idx_ofs_nxt = HWDATA[23:0];
        `EFE_OFS_SHAFT_ANG:   ang_nxt     = HWDATA[23:0];
        `EFE_OFS_SHAFT_TURNS: turns_nxt   = HWDATA[15:0];
        `EFE_OFS_PHASE:       phase_nxt   = HWDATA[11:0];
        default:              ctrl_nxt    = ctrl_r;
      endcase
    end
    fb_idx_nxt = fb_idx_evt ? fb_cnt : fb_idx_r;
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= '0;
      HRDATA    <= '0;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
      ctrl_r    <= efe_ctrl_t'(`EFE_CTRL_RST);
      idx_ofs_r <= '0;
      ang_r     <= '0;
      turns_r   <= '0;
      phase_r   <= '0;
      fb_idx_r  <= '0;
    end else begin
      wr_pend_r <= wr_pend_nxt;
      wr_addr_r <= wr_addr_nxt;
      HRDATA    <= hrdata_nxt;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
      ctrl_r    <= ctrl_nxt;
      idx_ofs_r <= idx_ofs_nxt;
      ang_r     <= ang_nxt;
      turns_r   <= turns_nxt;
      phase_r   <= phase_nxt;
      fb_idx_r  <= fb_idx_nxt;
    end
  end

  efe_qdec u_fb_dec (
    .clk       (CLK),
    .rst_n     (rst_n),
    .en        (fb_en),
    .step_mode (1'b0),
    .pin       (enc_s),
    .cnt_r     (fb_cnt),
    .idx_r     (fb_idx_evt)
  );

  efe_qdec u_gear_dec (
    .clk       (CLK),
    .rst_n     (rst_n),
    .en        (gear_en),
    .step_mode (ctrl_r.gearing_input_mode == `EFE_GEAR_STEP),
    .pin       (x5_s),
    .cnt_r     (gear_cnt),
    .idx_r     ()
  );

  // Quadrature emulation: a follower steps toward the shaft angle
  logic [39:0] pos;
  logic [4:0]  res;
  logic [4:0]  qsh;
  logic [4:0]  lsh;
  logic [23:0] step;
  logic [23:0] target;
  logic [23:0] delta;
  logic [23:0] emu_r;
  logic [23:0] emu_nxt;
  logic [4:0]  gap_r;
  logic [4:0]  gap_nxt;
  logic [1:0]  quad;
  logic        emu_on;
  logic        idx_hit;
  logic [31:0] tx_word;

  always_comb begin
    pos = {turns_r, ang_r};
    if (ctrl_r.dir_invert) begin
      pos = 40'h0000000000 - pos;
    end
    res = ctrl_r.emu_lines_log2;
    if (res < `EFE_RES_MIN) begin
      res = `EFE_RES_MIN;
    end else if (ctrl_r.src_resolver && res > `EFE_RES_MAX_RSV) begin
      res = `EFE_RES_MAX_RSV;
    end else if (res > `EFE_RES_MAX_ENC) begin
      res = `EFE_RES_MAX_ENC;
    end
    qsh     = `EFE_QUAD_TOP - res;
    lsh     = `EFE_LINE_TOP - res;
    step    = 24'h000001 << qsh;
    target  = pos[23:0] & ~(step - 24'h000001);
    delta   = target - emu_r;
    emu_on  = (ctrl_r.emulation_output_mode == `EFE_EMU_QUAD);
    quad    = 2'(emu_r >> qsh);
    idx_hit = ((emu_r >> lsh) == (idx_ofs_r >> lsh)) &&
              (quad == `EFE_IDX_QUAD);
    emu_nxt = emu_r;
    gap_nxt = (gap_r != 5'h00) ? gap_r - 5'h01 : gap_r;
    if (!emu_on) begin
      // Park on the target so enabling does not burst out stale counts
      emu_nxt = target;
    end else if ((delta != 24'h000000) && (gap_r == 5'h00)) begin
      // One count per edge time keeps the edge spacing at or above minimum
      emu_nxt = delta[23] ? emu_r - step : emu_r + step;
      gap_nxt = EDGE_CYC - 5'h01;
    end
    // Single-turn field is the top of the angle; revolutions sit above it
    tx_word = {pos[39:24], pos[23:8]} << (`EFE_MT_MAX - mt_w);
    if (ctrl_r.emu_gray) begin
      tx_word = tx_word ^ {1'b0, tx_word[31:1]};
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      emu_r <= '0;
      gap_r <= '0;
    end else begin
      emu_r <= emu_nxt;
      gap_r <= gap_nxt;
    end
  end

  efe_ssi_tx u_ssi_tx (
    .clk      (CLK),
    .rst_n    (rst_n),
    .en       (ctrl_r.emulation_output_mode == `EFE_EMU_SSI),
    .sclk     (x5_s.a),
    .word     (tx_word),
    .nbits    (nbits),
    .tout_cyc (tout_cyc),
    .dat_r    (tx_dat),
    .busy     (tx_busy)
  );

  // SSI feedback reader; waits a full timeout with clock high per frame
  efe_rx_st_t  rx_st_r;
  efe_rx_st_t  rx_st_nxt;
  logic [4:0]  rxdiv_r;
  logic [4:0]  rxdiv_nxt;
  logic [5:0]  rxn_r;
  logic [5:0]  rxn_nxt;
  logic [31:0] rxsh_r;
  logic [31:0] rxsh_nxt;
  logic [9:0]  rxgap_r;
  logic [9:0]  rxgap_nxt;
  logic        rxclk_nxt;
  logic        rx_en;

  assign rx_en = (ctrl_r.feedback_type_select == `EFE_FB_SSI) |
                 (ctrl_r.external_position_source == `EFE_EXT_SSI);
  assign rx_busy = (rx_st_r == RX_RUN);

  always_comb begin
    rx_st_nxt  = rx_st_r;
    rxdiv_nxt  = '0;
    rxn_nxt    = rxn_r;
    rxsh_nxt   = rxsh_r;
    rxgap_nxt  = rxgap_r;
    rxclk_nxt  = SSIF_CLK_O;
    ssi_rx_nxt = ssi_rx_r;
    unique case (rx_st_r)
      RX_GAP: begin
        rxclk_nxt = 1'b1;
        rxn_nxt   = '0;
        rxsh_nxt  = '0;
        if (!rx_en) begin
          rxgap_nxt = '0;
        end else if (rxgap_r >= tout_cyc) begin
          rxgap_nxt = '0;
          rx_st_nxt = RX_RUN;
        end else begin
          rxgap_nxt = rxgap_r + 10'h001;
        end
      end
      RX_RUN: begin
        rxdiv_nxt = rxdiv_r + 5'h01;
        if (rxdiv_r == HALF_CYC - 5'h01) begin
          rxdiv_nxt = '0;
          if (SSIF_CLK_O) begin
            rxclk_nxt = 1'b0;
            rxn_nxt   = rxn_r + 6'h01;
            if (rxn_r != 6'h00) begin
              rxsh_nxt = {rxsh_r[30:0], ssif_dat_s};
            end
          end else begin
            rxclk_nxt = 1'b1;
            if (rxn_r > nbits) begin
              rx_st_nxt  = RX_GAP;
              ssi_rx_nxt = ctrl_r.rx_gray ? gray2bin(rxsh_r) : rxsh_r;
            end
          end
        end
        if (!rx_en) begin
          rx_st_nxt = RX_GAP;
          rxclk_nxt = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      rx_st_r    <= RX_GAP;
      rxdiv_r    <= '0;
      rxn_r      <= '0;
      rxsh_r     <= '0;
      rxgap_r    <= '0;
      SSIF_CLK_O <= 1'b1;
      ssi_rx_r   <= '0;
    end else begin
      rx_st_r    <= rx_st_nxt;
      rxdiv_r    <= rxdiv_nxt;
      rxn_r      <= rxn_nxt;
      rxsh_r     <= rxsh_nxt;
      rxgap_r    <= rxgap_nxt;
      SSIF_CLK_O <= rxclk_nxt;
      ssi_rx_r   <= ssi_rx_nxt;
    end
  end

  // Pin drivers and commutation outputs
  logic        shake_nxt;
  logic [2:0]  hall_nxt;
  logic [11:0] cphase_nxt;
  efe_quad_t   x5o_nxt;
  efe_quad_t   x5oe_nxt;

  assign status = {22'h000000, WAKE_SHAKE_REQ, COMM_HALL, X5_O.b, X5_O.a,
                   tx_busy, rx_busy, fb_en, gear_en};

  always_comb begin
    shake_nxt = (ctrl_r.feedback_type_select == `EFE_FB_QUAD_SHAKE) &
                ~ctrl_r.shake_done;
    hall_nxt  = (ctrl_r.feedback_type_select == `EFE_FB_HALL) ?
                hall_s : 3'h0;
    cphase_nxt = 12'h000;
    if ((ctrl_r.feedback_type_select == `EFE_FB_QUAD_STORE) ||
        ((ctrl_r.feedback_type_select == `EFE_FB_QUAD_SHAKE) &&
         ctrl_r.shake_done)) begin
      cphase_nxt = phase_r;
    end
    x5o_nxt  = '0;
    x5oe_nxt = '0;
    if (emu_on) begin
      x5o_nxt  = '{z: idx_hit, b: quad[1], a: quad[1] ^ quad[0]};
      x5oe_nxt = '{z: 1'b1, b: 1'b1, a: 1'b1};
    end else if (ctrl_r.emulation_output_mode == `EFE_EMU_SSI) begin
      x5o_nxt  = '{z: 1'b0, b: tx_dat, a: 1'b0};
      x5oe_nxt = '{z: 1'b0, b: 1'b1, a: 1'b0};
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      WAKE_SHAKE_REQ <= 1'b0;
      COMM_HALL      <= '0;
      COMM_PHASE     <= '0;
      X5_O           <= '0;
      X5_OE          <= '0;
    end else begin
      WAKE_SHAKE_REQ <= shake_nxt;
      COMM_HALL      <= hall_nxt;
      COMM_PHASE     <= cphase_nxt;
      X5_O           <= x5o_nxt;
      X5_OE          <= x5oe_nxt;
    end
  end
endmodule
`default_nettype wire

/* File: src/efe_cfg.svh */
`ifndef EFE_CFG_SVH
`define EFE_CFG_SVH

`define EFE_CLK_MHZ         100
`define EFE_NS2CYC(ns)      ((((ns) * `EFE_CLK_MHZ) + 999) / 1000)
`define EFE_EDGE_NS         200
`define EFE_SSIR_HALF_NS    300
`define EFE_TOUT_SHORT_NS   1300
`define EFE_TOUT_LONG_NS    10000
`define EFE_EDGE_CYC        `EFE_NS2CYC(`EFE_EDGE_NS)
`define EFE_SSIR_HALF_CYC   `EFE_NS2CYC(`EFE_SSIR_HALF_NS)
`define EFE_TOUT_SHORT_CYC  `EFE_NS2CYC(`EFE_TOUT_SHORT_NS)
`define EFE_TOUT_LONG_CYC   `EFE_NS2CYC(`EFE_TOUT_LONG_NS)

`define EFE_OFS_CTRL        8'h00
`define EFE_OFS_IDX_OFS     8'h04
`define EFE_OFS_SHAFT_ANG   8'h08
`define EFE_OFS_SHAFT_TURNS 8'h0C
`define EFE_OFS_PHASE       8'h10
`define EFE_OFS_FB_CNT      8'h14
`define EFE_OFS_GEAR_CNT    8'h18
`define EFE_OFS_SSI_RX      8'h1C
`define EFE_OFS_STATUS      8'h20
`define EFE_OFS_FB_IDX      8'h24

`define EFE_CTRL_RST        32'h018C000D

`define EFE_FB_SSI          5'h09
`define EFE_FB_QUAD_STORE   5'h0D
`define EFE_FB_HALL         5'h12
`define EFE_FB_QUAD_SHAKE   5'h13
`define EFE_EXT_SSI         3'h5
`define EFE_GEAR_QUAD       3'h3
`define EFE_GEAR_STEP       3'h4
`define EFE_EMU_OFF         2'h0
`define EFE_EMU_QUAD        2'h1
`define EFE_EMU_SSI         2'h2

`define EFE_RES_MIN         5'h08
`define EFE_RES_MAX_ENC     5'h13
`define EFE_RES_MAX_RSV     5'h0C
`define EFE_MT_MIN          5'h0C
`define EFE_MT_MAX          5'h10
`define EFE_ST_BITS         6'h10
`define EFE_QUAD_TOP        5'h16
`define EFE_LINE_TOP        5'h18
`define EFE_IDX_QUAD        2'h2

`endif

/* File: src/efe_pkg.sv */
package efe_pkg;

  typedef struct packed {
    logic z;
    logic b;
    logic a;
  } efe_quad_t;

  typedef struct packed {
    logic [2:0] spare;
    logic       shake_done;
    logic       dir_invert;
    logic       src_resolver;
    logic [4:0] emu_lines_log2;
    logic [4:0] multiturn_bit_width;
    logic       serial_frame_timeout;
    logic       emu_gray;
    logic       rx_gray;
    logic [1:0] emulation_output_mode;
    logic [2:0] gearing_input_mode;
    logic [2:0] external_position_source;
    logic [4:0] feedback_type_select;
  } efe_ctrl_t;

  typedef enum logic [1:0] {
    TX_IDLE  = 2'b01,
    TX_SHIFT = 2'b10
  } efe_tx_st_t;

  typedef enum logic [1:0] {
    RX_GAP = 2'b01,
    RX_RUN = 2'b10
  } efe_rx_st_t;

endpackage

/* File: src/efe_qdec.sv */
`timescale 1ns/100ps
`default_nettype none
module efe_qdec (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              en,
  input  wire logic              step_mode,
  input  wire efe_pkg::efe_quad_t pin,
  output logic [31:0]            cnt_r,
  output logic                   idx_r
);
  import efe_pkg::*;

  efe_quad_t   prev_r;
  efe_quad_t   prev_nxt;
  logic [31:0] cnt_nxt;
  logic        idx_nxt;
  logic        a_chg;
  logic        b_chg;

  always_comb begin
    prev_nxt = pin;
    cnt_nxt  = cnt_r;
    a_chg    = pin.a ^ prev_r.a;
    b_chg    = pin.b ^ prev_r.b;
    idx_nxt  = en & pin.z & ~prev_r.z;
    if (en) begin
      if (step_mode) begin
        // Direction high counts up; only the step rising edge counts
        if (pin.a & ~prev_r.a) begin
          cnt_nxt = pin.b ? cnt_r + 32'h1 : cnt_r - 32'h1;
        end
      end else if (a_chg ^ b_chg) begin
        // A leading B counts up; a double change is a lost edge and skipped
        cnt_nxt = (pin.a ^ prev_r.b) ? cnt_r + 32'h1 : cnt_r - 32'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_r <= '0;
      cnt_r  <= '0;
      idx_r  <= 1'b0;
    end else begin
      prev_r <= prev_nxt;
      cnt_r  <= cnt_nxt;
      idx_r  <= idx_nxt;
    end
  end
endmodule
`default_nettype wire

/* File: src/efe_ssi_tx.sv */
`timescale 1ns/100ps
`default_nettype none
module efe_ssi_tx (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        en,
  input  wire logic        sclk,
  input  wire logic [31:0] word,
  input  wire logic [5:0]  nbits,
  input  wire logic [9:0]  tout_cyc,
  output logic             dat_r,
  output logic             busy
);
  import efe_pkg::*;

  efe_tx_st_t  st_r;
  efe_tx_st_t  st_nxt;
  logic [31:0] sh_r;
  logic [31:0] sh_nxt;
  logic [5:0]  left_r;
  logic [5:0]  left_nxt;
  logic [9:0]  tcnt_r;
  logic [9:0]  tcnt_nxt;
  logic        prev_r;
  logic        dat_nxt;

  assign busy = (st_r == TX_SHIFT);

  always_comb begin
    st_nxt   = st_r;
    sh_nxt   = sh_r;
    left_nxt = left_r;
    tcnt_nxt = tcnt_r;
    dat_nxt  = dat_r;
    unique case (st_r)
      TX_IDLE: begin
        dat_nxt  = 1'b1;
        tcnt_nxt = '0;
        // Position is frozen on the first falling clock edge
        if (en & prev_r & ~sclk) begin
          sh_nxt   = word;
          left_nxt = nbits;
          st_nxt   = TX_SHIFT;
        end
      end
      TX_SHIFT: begin
        if (~prev_r & sclk) begin
          if (left_r != 6'h00) begin
            dat_nxt  = sh_r[31];
            sh_nxt   = {sh_r[30:0], 1'b0};
            left_nxt = left_r - 6'h01;
          end else begin
            dat_nxt = 1'b0;
          end
        end
        // Data stays low after the last bit until the clock rests high
        if (!sclk) begin
          tcnt_nxt = '0;
        end else if (tcnt_r >= tout_cyc) begin
          st_nxt  = TX_IDLE;
          dat_nxt = 1'b1;
        end else begin
          tcnt_nxt = tcnt_r + 10'h001;
        end
        if (!en) begin
          st_nxt  = TX_IDLE;
          dat_nxt = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r   <= TX_IDLE;
      sh_r   <= '0;
      left_r <= '0;
      tcnt_r <= '0;
      prev_r <= 1'b1;
      dat_r  <= 1'b1;
    end else begin
      st_r   <= st_nxt;
      sh_r   <= sh_nxt;
      left_r <= left_nxt;
      tcnt_r <= tcnt_nxt;
      prev_r <= sclk;
      dat_r  <= dat_nxt;
    end
  end
endmodule
`default_nettype wire

/* File: verification/efe_top_sva.sv */
`timescale 1ns/100ps
`default_nettype none
module efe_top_sva (
  input wire logic               CLK,
  input wire logic               ARST_N,
  input wire logic               HSEL,
  input wire logic [1:0]         HTRANS,
  input wire logic               HWRITE,
  input wire logic               HREADY,
  input wire logic [31:0]        HRDATA,
  input wire logic               HREADYOUT,
  input wire logic               HRESP,
  input wire efe_pkg::efe_quad_t X5_I,
  input wire efe_pkg::efe_quad_t X5_O,
  input wire efe_pkg::efe_quad_t X5_OE,
  input wire logic               SSIF_CLK_O,
  input wire logic               WAKE_SHAKE_REQ,
  input wire logic [11:0]        COMM_PHASE
);
  import efe_pkg::*;
  logic [1:0]  ab_q_r;
  logic [4:0]  gap_r;
  logic [10:0] hi_r;
  logic        ab_chg;
  logic        rd;
  assign ab_chg = {X5_O.b, X5_O.a} != ab_q_r;
  assign rd = HSEL && HTRANS[1] && HREADY && !HWRITE;
  // Counters saturate so long idle stretches never wrap
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ab_q_r <= 2'h0;
      gap_r <= 5'h1F;
      hi_r <= 11'h000;
    end else begin
      ab_q_r <= {X5_O.b, X5_O.a};
      gap_r <= ab_chg ? 5'h00 : gap_r + {4'h0, gap_r != 5'h1F};
      hi_r <= X5_I.a ? hi_r + {10'h0, hi_r != 11'h7FF} : 11'h000;
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  sequence s_lo8;
    !SSIF_CLK_O [*8];
  endsequence
  AST_OKAY: assert property (!HRESP && HREADYOUT)
    else $error("Bus answer not ready OKAY");
  AST_RDATA_HOLD: assert property (!$past(rd) |-> $stable(HRDATA))
    else $error("Read data moved without a read");
  AST_IDX_AB: assert property (X5_OE.z && X5_O.z |-> X5_O.a && X5_O.b)
    else $error("Index outside A=B=1");
  AST_AB_ONE: assert property (X5_OE.a && $past(X5_OE.a)
    |-> !(X5_O.a != ab_q_r[0] && X5_O.b != ab_q_r[1]))
    else $error("A and B switched together");
  AST_AB_GAP: assert property (X5_OE.a && $past(X5_OE.a) && ab_chg
    |-> gap_r >= 5'd19)
    else $error("Emulated edges too close");
  AST_SSI_IDLE: assert property (X5_OE.b && !X5_OE.a &&
    $past(X5_OE.b, 4) && hi_r > 11'd1010 |-> X5_O.b)
    else $error("Serial data not idle after timeout");
  AST_RD_LOW: assert property ($fell(SSIF_CLK_O) |-> ##1 s_lo8)
    else $error("Reader clock low phase too short");
  AST_WAKE: assert property (WAKE_SHAKE_REQ |-> COMM_PHASE == 12'h000)
    else $error("Phase given before shake done");
endmodule
bind efe_top efe_top_sva u_sva (.CLK, .ARST_N, .HSEL, .HTRANS, .HWRITE,
  .HREADY, .HRDATA, .HREADYOUT, .HRESP, .X5_I, .X5_O, .X5_OE,
  .SSIF_CLK_O, .WAKE_SHAKE_REQ, .COMM_PHASE);
`default_nettype wire

/* File: verification/efe_ssi_rdr.sv */
`timescale 1ns/100ps
`default_nettype none
module efe_ssi_rdr (
  input wire logic       go,
  input wire logic [5:0] nbits,
  input wire logic       dat,
  output logic           sclk,
  output logic [31:0]    word,
  output logic           done
);
  initial begin
    sclk = 1'b1;
    done = 1'b0;
    word = 32'h0;
  end
  always @(posedge go) begin
    done = 1'b0;
    word = 32'h0;
    for (int i = 0; i <= nbits; i++) begin
      sclk = 1'b0;
      if (i > 0) word = {word[30:0], dat};
      #62.5 sclk = 1'b1;
      #62.5;
    end
    // Clock idles high; next read only after the long timeout
    #11500 done = 1'b1;
  end
endmodule
`default_nettype wire

/* File: verification/tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb;
  import efe_pkg::*;
  localparam int ES = 67;
  logic CLK = 0, ARST_N = 0, HSEL = 0, HWRITE = 0, SSIF_DAT_I = 1, go = 0;
  logic [31:0] HADDR = 0, HWDATA = 0, HRDATA, rv, d, t, w, fbw = 0, shf = 0;
  logic [1:0] HTRANS = 0, q = 0;
  logic [2:0] HALL_I = 0, COMM_HALL;
  logic [5:0] nb = 6'd28;
  logic [11:0] COMM_PHASE;
  logic HREADYOUT, HRESP, SSIF_CLK_O, WAKE_SHAKE_REQ, sclk, done;
  efe_quad_t ENC_I = 0, x5_r = 0, x5_i, X5_O, X5_OE;
  int n_mismatch = 0, checks_done = 0, cyc = 0, n, i;
  realtime t_hi = 0;
  assign x5_i = {x5_r.z, x5_r.b, x5_r.a & sclk};
  always #5 CLK = ~CLK;
  efe_top dut (.CLK, .ARST_N, .HSEL, .HADDR, .HTRANS, .HWRITE,
    .HSIZE(3'h2), .HWDATA, .HREADY(HREADYOUT), .HRDATA, .HREADYOUT,
    .HRESP, .ENC_I, .HALL_I, .X5_I(x5_i), .X5_O, .X5_OE, .SSIF_DAT_I,
    .SSIF_CLK_O, .WAKE_SHAKE_REQ, .COMM_HALL, .COMM_PHASE);
  efe_ssi_rdr rdr (.go, .nbits(nb), .dat(X5_OE.b ? X5_O.b : 1'b1),
    .sclk, .word(w), .done);
  // Encoder stand-in: reload only when the clock falls after a long gap
  always @(negedge SSIF_CLK_O) if ($realtime - t_hi > 1000.0) shf <= fbw;
  always @(posedge SSIF_CLK_O) begin
    t_hi = $realtime;
    SSIF_DAT_I <= shf[31];
    shf <= shf << 1;
  end
  task automatic wt(input int c);
    repeat (c) @(posedge CLK);
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] v);
    HSEL <= 1;
    HADDR <= {24'h0, a};
    HWRITE <= wr;
    HTRANS <= 2'h2;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    HSEL <= 0;
    HTRANS <= 2'h0;
    HWDATA <= v;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    rv = HRDATA;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(0, a, 0);
    chk(rv, exp);
  endtask
  function automatic logic [1:0] qp(input logic [1:0] v);
    return {v[1], v[1] ^ v[0]};
  endfunction
  function automatic logic [31:0] gr(input logic [31:0] v);
    return v ^ (v >> 1);
  endfunction
  function automatic logic [31:0] ctl(input logic [4:0] ty,
    input logic [4:0] mt, input logic [31:0] o);
    return o | {11'h0, mt, 11'h0, ty};
  endfunction
  task automatic mv(input bit x5, input int c, input bit up, input bit stp);
    repeat (c) begin
      if (stp) begin
        x5_r.b <= up;
        wt(ES);
        x5_r.a <= 1;
        wt(ES);
        x5_r.a <= 0;
      end else begin
        q = up ? q + 2'h1 : q - 2'h1;
        if (x5) {x5_r.b, x5_r.a} <= qp(q);
        else {ENC_I.b, ENC_I.a} <= qp(q);
      end
      wt(ES);
    end
  endtask
  task report_and_stop;
    $display("checks=%0d mismatches=%0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_mismatch++;
      report_and_stop;
    end
  end
  initial begin
    n = $urandom(15);
    wt(8);
    ARST_N <= 1;
    wt(3);
    rdc(8'h00, 32'h018C000D);
    d = $urandom;
    bus(1, 8'h04, d);
    rdc(8'h04, {8'h0, d[23:0]});
    bus(1, 8'h30, d);
    rdc(8'h30, 0);
    bus(1, 8'h10, d);
    wt(3);
    chk(32'(COMM_PHASE), {20'h0, d[11:0]});
    HALL_I <= 3'($urandom);
    bus(1, 0, ctl(19, 12, 0));
    wt(4);
    chk(32'({WAKE_SHAKE_REQ, COMM_PHASE}), 32'h1000);
    bus(1, 0, ctl(19, 12, 32'h10000000));
    wt(4);
    chk(32'({WAKE_SHAKE_REQ, COMM_PHASE}), {20'h0, d[11:0]});
    bus(1, 0, ctl(18, 12, 0));
    wt(6);
    chk(32'(COMM_HALL), 32'(HALL_I));
    $display("commutation test done");
    n = 4 * $urandom_range(10, 2);
    bus(1, 0, ctl(13, 12, 0));
    mv(0, n, 1, 0);
    mv(0, 3, 0, 0);
    rdc(8'h14, n - 3);
    bus(1, 0, ctl(13, 12, 32'h300));
    mv(1, n, 1, 0);
    bus(1, 0, ctl(13, 12, 32'h400));
    mv(1, 5, 0, 1);
    mv(1, 2, 1, 1);
    rdc(8'h18, n - 3);
    // Feedback index edge snapshots the feedback count
    ENC_I.z <= 1;
    wt(8);
    rdc(8'h24, n - 3);
    $display("counter test done");
    bus(1, 8'h04, 0);
    bus(1, 0, ctl(13, 12, 32'h01000800));
    x5_r <= 3'b001;
    bus(1, 8'h08, 32'h8000);
    wt(100);
    chk(32'(X5_O), {29'h0, 1'b1, qp(2'h2)});
    bus(1, 8'h08, 32'hC000);
    wt(60);
    chk(32'(X5_O), {30'h0, qp(2'h3)});
    bus(1, 0, ctl(13, 12, 32'h09000800));
    wt(200);
    chk(32'(X5_O), {30'h0, qp(2'h1)});
    $display("quadrature emulation test done");
    for (i = 0; i < 4; i++) begin
      nb = i[1] ? 6'd32 : 6'd28;
      d = $urandom;
      t = $urandom;
      bus(1, 8'h08, d);
      bus(1, 8'h0C, t);
      bus(1, 0, ctl(13, 5'(nb - 16), {i[0], 14'h0} | 32'h1000 |
        ($urandom & 32'h8000)));
      go <= 1;
      wt(1);
      for (n = 0; n < 3000 && !done; n++) wt(1);
      go <= 0;
      d = {t[15:0], d[23:8]} << (32 - nb);
      chk(w, (i[0] ? gr(d) : d) >> (32 - nb));
    end
    $display("serial emulation test done");
    for (i = 0; i < 2; i++) begin
      d = $urandom & 32'h0FFFFFFF;
      fbw = (i[0] ? gr(d) : d) << 4;
      // Binary pass uses the external source select, Gray pass the type
      bus(1, 0, ctl(i[0] ? 5'd9 : 5'd13, 12,
        {18'h0, i[0], 13'h0} | (i[0] ? 32'h0 : 32'hA0)));
      rv = 0;
      for (n = 0; n < 40 && rv !== d; n++) begin
        wt(100);
        bus(0, 8'h1C, 0);
      end
      chk(rv, d);
    end
    $display("serial feedback test done");
    report_and_stop;
  end
endmodule
`default_nettype wire
